// *** include/console_pkg.sv ***
package console_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int MOD_WORDS = 4096;
    localparam int MAX_WORDS = 65536;
    localparam int MOD_BITS = 12;
    localparam int MOD_CNT_W = 5;
    localparam int MEM_WORDS = 4096;

    localparam logic [7:0] WB_CTRL = 8'h00;
    localparam logic [7:0] WB_SEL = 8'h04;
    localparam logic [7:0] WB_KEY = 8'h08;
    localparam logic [7:0] WB_CMD = 8'h0C;
    localparam logic [7:0] WB_DISP = 8'h10;
    localparam logic [7:0] WB_STAT = 8'h14;
    localparam logic [7:0] WB_SUM = 8'h18;
    localparam logic [7:0] WB_MEMSZ = 8'h1C;

    localparam int CMD_CLEAR = 0;
    localparam int CMD_ENTER = 1;
    localparam int CMD_RUN = 2;
    localparam int CMD_HALT = 3;
    localparam int CMD_INIT = 4;

    localparam logic [4:0] MEMSZ_RST = 5'h01;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONE = 16'h0001;

    localparam logic [3:0] DEV_TTY = 4'h2;
    localparam logic [3:0] DEV_CARD = 4'h3;
    localparam logic [3:0] DEV_TAPE = 4'h4;
    localparam logic [3:0] DEV_MT_LO = 4'hB;
    localparam logic [3:0] DEV_MT_HI = 4'hE;

    localparam logic [4:0] OP_CALL_SHORT = 5'h01;
    localparam logic [4:0] OP_CALL_LONG = 5'h02;
    localparam logic [4:0] OP_ARM = 5'h03;
    localparam logic [4:0] OP_ARM_ALT = 5'h04;
    localparam logic [4:0] OP_DISARM = 5'h05;
    localparam logic [4:0] OP_DISARM_ALT = 5'h06;

    typedef enum logic [1:0] {
        MODE_RUN    = 2'b00,
        MODE_HALT   = 2'b01,
        MODE_STEP   = 2'b10,
        MODE_VSPEED = 2'b11
    } run_mode_t;

    typedef enum logic [2:0] {
        SEL_A     = 3'b000,
        SEL_B     = 3'b001,
        SEL_X     = 3'b010,
        SEL_P     = 3'b011,
        SEL_MADDR = 3'b100,
        SEL_MDATA = 3'b101,
        SEL_INST1 = 3'b110,
        SEL_INST2 = 3'b111
    } reg_sel_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_FETCH  = 4'b0001,
        ST_EXEC   = 4'b0010,
        ST_BSTART = 4'b0011,
        ST_BWAIT  = 4'b0100,
        ST_BSTORE = 4'b0101,
        ST_IOWAIT = 4'b0110,
        ST_SERV   = 4'b0111
    } ctl_state_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [3:0]  dev;
        logic        ctrl;
        logic [15:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic        ack;
        logic        present;
        logic [15:0] rdata;
    } io_rsp_t;

endpackage

// *** verilog/console_control.sv ***
// Operation
// - Fetch, decode, execute only when not held
// - Memory in 4096-word modules, 16-bit address
// - Absent memory: no write, reads zero
// - One peripheral on the shared bus
// - Input from absent device returns zero
// - Output to absent device does nothing
// - Bootstrap device number taken from X
// - Start medium except TTY, skip zeros, pack until zero
// - After zero word, jump to key register value
// - Checksum sums loaded words, overflow ignored
// - Stopped modes show and overwrite selected register
// - Selector ignored while running
// - Console works only with key normal; the code gates only display update and enter on it
// - Enter without data in halt mode advances memory address
// - Keyed enter in halt mode writes, then advances address
// - Instruction one shows and replaces word at P
// - Instruction two shows and replaces next word
// - Step mode runs one step per run
// - Call, arm, disarm run next instruction first
// - P always holds next instruction address
module console_control (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [31:0]            wb_dat_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic                   wb_we_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic                   key_normal_i,
    input  wire logic                   irq_req_i,
    input  wire logic                   dmc_req_i,
    output console_pkg::io_req_t        io_req_o,
    input  wire console_pkg::io_rsp_t   io_rsp_i,
    output logic                        serv_o
);

    logic [15:0] mem [0:console_pkg::MEM_WORDS-1];

    logic [15:0] a_reg, b_reg, x_reg, p_reg, ir_reg;
    logic [15:0] maddr_reg, key_reg, sum_reg, disp_reg;
    logic [15:0] byte_hi_reg;
    logic        have_hi_reg, seen_data_reg, keyed_reg, hold_reg;
    logic        boot_reg, step_done_reg;
    logic [4:0]  memsz_reg;
    console_pkg::run_mode_t  mode_reg;
    console_pkg::reg_sel_t   sel_reg;
    console_pkg::ctl_state_t st_reg;
    console_pkg::io_req_t    io_reg;
    logic [31:0] wb_dat_reg;
    logic        wb_ack_reg;
    logic        key_s1_reg, key_s2_reg, irq_s1_reg, irq_s2_reg;
    logic        dmc_s1_reg, dmc_s2_reg;

    assign io_req_o = io_reg;
    assign wb_dat_o = wb_dat_reg;
    assign wb_ack_o = wb_ack_reg;
    assign serv_o   = hold_reg;

    function automatic logic present(input logic [15:0] adr,
                                     input logic [4:0]  modules);
        present = {1'b0, adr[15:console_pkg::MOD_BITS]} < modules;
    endfunction

    function automatic logic [15:0] rd_mem(input logic [15:0] adr,
                                           input logic [4:0]  modules);
        rd_mem = present(adr, modules)
            ? mem[adr[console_pkg::MOD_BITS-1:0]]
            : console_pkg::WORD_ZERO;
    endfunction

    function automatic logic is_chain(input logic [15:0] w);
        logic [4:0] op;
        op = w[15:11];
        is_chain = (op == console_pkg::OP_CALL_SHORT)
            || (op == console_pkg::OP_CALL_LONG)
            || (op == console_pkg::OP_ARM)
            || (op == console_pkg::OP_ARM_ALT)
            || (op == console_pkg::OP_DISARM)
            || (op == console_pkg::OP_DISARM_ALT);
    endfunction

    wire wb_hit   = wb_cyc_i && wb_stb_i && !wb_ack_reg;
    wire wb_wr    = wb_hit && wb_we_i && wb_sel_i[0];
    wire stopped  = mode_reg != console_pkg::MODE_RUN;
    wire con_ok   = key_s2_reg && stopped;
    wire cmd_wr   = wb_wr && (wb_adr_i == console_pkg::WB_CMD);
    wire do_clear = cmd_wr && wb_dat_i[console_pkg::CMD_CLEAR];
    wire do_enter = cmd_wr && wb_dat_i[console_pkg::CMD_ENTER] && con_ok;
    wire do_run   = cmd_wr && wb_dat_i[console_pkg::CMD_RUN];
    wire do_halt  = cmd_wr && wb_dat_i[console_pkg::CMD_HALT];
    wire do_init  = cmd_wr && wb_dat_i[console_pkg::CMD_INIT];
    wire pending  = irq_s2_reg || dmc_s2_reg;
    wire held     = (mode_reg == console_pkg::MODE_HALT)
                    || ((mode_reg != console_pkg::MODE_RUN)
                        && step_done_reg)
                    || pending;
    wire [15:0] p_next1 = p_reg + console_pkg::WORD_ONE;
    wire [15:0] ma_next = maddr_reg + console_pkg::WORD_ONE;
    wire [15:0] inst1_w = rd_mem(p_reg, memsz_reg);
    wire [15:0] inst2_w = rd_mem(p_next1, memsz_reg);
    wire [15:0] mdat_w  = rd_mem(maddr_reg, memsz_reg);
    wire boot_dev_ok = (x_reg[3:0] >= console_pkg::DEV_TTY
                        && x_reg[3:0] <= console_pkg::DEV_TAPE)
                       || (x_reg[3:0] >= console_pkg::DEV_MT_LO
                        && x_reg[3:0] <= console_pkg::DEV_MT_HI);
    wire [15:0] io_in = io_rsp_i.present ? io_rsp_i.rdata
                                          : console_pkg::WORD_ZERO;
    wire [15:0] boot_word = {byte_hi_reg[7:0], io_in[7:0]};

    logic [15:0] disp_next;
    always_comb begin
        case (sel_reg)
            console_pkg::SEL_A:     disp_next = a_reg;
            console_pkg::SEL_B:     disp_next = b_reg;
            console_pkg::SEL_X:     disp_next = x_reg;
            console_pkg::SEL_P:     disp_next = p_reg;
            console_pkg::SEL_MADDR: disp_next = maddr_reg;
            console_pkg::SEL_MDATA: disp_next = mdat_w;
            console_pkg::SEL_INST1: disp_next = inst1_w;
            console_pkg::SEL_INST2: disp_next = inst2_w;
            default:                disp_next = console_pkg::WORD_ZERO;
        endcase
    end

    logic [31:0] rd_next;
    always_comb begin
        case (wb_adr_i)
            console_pkg::WB_CTRL:  rd_next = {29'h0, boot_reg, mode_reg};
            console_pkg::WB_SEL:   rd_next = {29'h0, sel_reg};
            console_pkg::WB_KEY:   rd_next = {16'h0, key_reg};
            console_pkg::WB_DISP:  rd_next = {16'h0, disp_reg};
            console_pkg::WB_STAT:  rd_next = {24'h0, 1'b0, st_reg,
                                              pending, held, hold_reg};
            console_pkg::WB_SUM:   rd_next = {16'h0, sum_reg};
            console_pkg::WB_MEMSZ: rd_next = {27'h0, memsz_reg};
            default:               rd_next = 32'h0000_0000;
        endcase
    end

    // One-cycle acknowledge; unmapped reads return zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_reg <= 1'b0;
            wb_dat_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_reg <= wb_hit;
            wb_dat_reg <= wb_hit ? rd_next : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {key_s1_reg, key_s2_reg, irq_s1_reg, irq_s2_reg} <= 4'h0;
            {dmc_s1_reg, dmc_s2_reg} <= 2'h0;
        end else if (ce_i) begin
            key_s1_reg <= key_normal_i;
            key_s2_reg <= key_s1_reg;
            irq_s1_reg <= irq_req_i;
            irq_s2_reg <= irq_s1_reg;
            dmc_s1_reg <= dmc_req_i;
            dmc_s2_reg <= dmc_s1_reg;
        end
    end

    // Writes to absent memory are dropped.
    always_ff @(posedge clk_i) begin
        if (ce_i && !rst_i) begin
            if (do_enter && keyed_reg && sel_reg == console_pkg::SEL_MDATA
                && mode_reg == console_pkg::MODE_HALT
                && present(maddr_reg, memsz_reg))
                mem[maddr_reg[11:0]] <= key_reg;
            else if (do_enter && keyed_reg
                     && sel_reg == console_pkg::SEL_INST1
                     && present(p_reg, memsz_reg))
                mem[p_reg[11:0]] <= key_reg;
            else if (do_enter && keyed_reg
                     && sel_reg == console_pkg::SEL_INST2
                     && present(p_next1, memsz_reg))
                mem[p_next1[11:0]] <= key_reg;
            else if (st_reg == console_pkg::ST_BWAIT && io_rsp_i.ack
                     && have_hi_reg && present(p_reg, memsz_reg))
                mem[p_reg[11:0]] <= boot_word;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_reg <= 16'h0000;
            b_reg <= 16'h0000;
            x_reg <= 16'h0000;
            p_reg <= 16'h0000;
            ir_reg <= 16'h0000;
            maddr_reg <= 16'h0000;
            key_reg <= 16'h0000;
            sum_reg <= 16'h0000;
            disp_reg <= 16'h0000;
            byte_hi_reg <= 16'h0000;
            {have_hi_reg, seen_data_reg, keyed_reg} <= 3'h0;
            {hold_reg, boot_reg, step_done_reg} <= 3'h0;
            memsz_reg <= console_pkg::MEMSZ_RST;
            mode_reg <= console_pkg::MODE_HALT;
            sel_reg <= console_pkg::SEL_A;
            st_reg <= console_pkg::ST_IDLE;
            io_reg <= '0;
        end else if (ce_i) begin
            if (con_ok)
                disp_reg <= disp_next;
            if (wb_wr && wb_adr_i == console_pkg::WB_CTRL) begin
                mode_reg <= console_pkg::run_mode_t'(wb_dat_i[1:0]);
                boot_reg <= wb_dat_i[2];
                step_done_reg <= 1'b1;
            end
            if (wb_wr && wb_adr_i == console_pkg::WB_SEL)
                sel_reg <= console_pkg::reg_sel_t'(wb_dat_i[2:0]);
            if (wb_wr && wb_adr_i == console_pkg::WB_MEMSZ)
                memsz_reg <= wb_dat_i[4:0];
            if (do_clear) begin
                key_reg <= console_pkg::WORD_ZERO;
                keyed_reg <= 1'b1;
            end else if (wb_wr && wb_adr_i == console_pkg::WB_KEY)
                key_reg <= wb_dat_i[15:0];
            if (do_halt)
                mode_reg <= console_pkg::MODE_HALT;
            if (do_enter) begin
                keyed_reg <= 1'b0;
                case (sel_reg)
                    console_pkg::SEL_A: if (keyed_reg) a_reg <= key_reg;
                    console_pkg::SEL_B: if (keyed_reg) b_reg <= key_reg;
                    console_pkg::SEL_X: if (keyed_reg) x_reg <= key_reg;
                    console_pkg::SEL_P: if (keyed_reg) p_reg <= key_reg;
                    console_pkg::SEL_MADDR:
                        if (keyed_reg) maddr_reg <= key_reg;
                    console_pkg::SEL_MDATA:
                        if (mode_reg == console_pkg::MODE_HALT)
                            maddr_reg <= ma_next;
                    default: ;
                endcase
            end
            if (do_run)
                step_done_reg <= 1'b0;
            case (st_reg)
                console_pkg::ST_IDLE: begin
                    if (do_init && boot_reg && boot_dev_ok) begin
                        sum_reg <= console_pkg::WORD_ZERO;
                        seen_data_reg <= 1'b0;
                        have_hi_reg <= 1'b0;
                        st_reg <= (x_reg[3:0] == console_pkg::DEV_TTY)
                            ? console_pkg::ST_BWAIT
                            : console_pkg::ST_BSTART;
                    end else if (!held && !do_halt)
                        st_reg <= console_pkg::ST_FETCH;
                end
                console_pkg::ST_FETCH: begin
                    ir_reg <= inst1_w;
                    p_reg <= p_next1;
                    st_reg <= console_pkg::ST_EXEC;
                end
                console_pkg::ST_EXEC: begin
                    if (is_chain(ir_reg))
                        st_reg <= console_pkg::ST_FETCH;
                    else begin
                        if (mode_reg != console_pkg::MODE_RUN)
                            step_done_reg <= 1'b1;
                        st_reg <= (mode_reg == console_pkg::MODE_RUN)
                            ? console_pkg::ST_IDLE : console_pkg::ST_SERV;
                    end
                end
                console_pkg::ST_SERV: begin
                    hold_reg <= 1'b1;
                    st_reg <= console_pkg::ST_IDLE;
                end
                console_pkg::ST_BSTART: begin
                    io_reg <= '{req: 1'b1, write: 1'b1, dev: x_reg[3:0],
                                ctrl: 1'b1, wdata: console_pkg::WORD_ONE};
                    st_reg <= console_pkg::ST_IOWAIT;
                end
                console_pkg::ST_IOWAIT: begin
                    if (io_rsp_i.ack || !io_rsp_i.present) begin
                        io_reg <= '0;
                        st_reg <= console_pkg::ST_BWAIT;
                    end
                end
                console_pkg::ST_BWAIT: begin
                    io_reg <= '{req: 1'b1, write: 1'b0, dev: x_reg[3:0],
                                ctrl: 1'b0, wdata: console_pkg::WORD_ZERO};
                    if (io_rsp_i.ack && io_reg.req) begin
                        io_reg <= '0;
                        if (seen_data_reg || io_in[7:0] != 8'h00) begin
                            seen_data_reg <= 1'b1;
                            if (!have_hi_reg) begin
                                byte_hi_reg <= io_in;
                                have_hi_reg <= 1'b1;
                            end else begin
                                have_hi_reg <= 1'b0;
                                sum_reg <= sum_reg + boot_word;
                                p_reg <= p_next1;
                                if (boot_word == console_pkg::WORD_ZERO)
                                    st_reg <= console_pkg::ST_BSTORE;
                            end
                        end
                    end
                end
                console_pkg::ST_BSTORE: begin
                    p_reg <= key_reg;
                    boot_reg <= 1'b0;
                    st_reg <= console_pkg::ST_IDLE;
                end
                default: st_reg <= console_pkg::ST_IDLE;
            endcase
            if (st_reg != console_pkg::ST_SERV && hold_reg && !held)
                hold_reg <= 1'b0;
        end
    end

endmodule

// *** testbench/console_checker.sv ***
module console_checker (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 ce_i,
    input wire logic [7:0]           wb_adr_i,
    input wire logic                 wb_we_i,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 wb_ack_o,
    input wire console_pkg::io_req_t io_req_o,
    input wire console_pkg::io_rsp_t io_rsp_i,
    input wire logic                 serv_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_next_edge:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
            |=> wb_ack_o)
        else $error("Bus request not answered.");
    a_ack_one_pulse:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack too long.");
    a_ack_has_cause:
        assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("Ack without request.");
    a_unmapped_zero:
        assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h1C
            |-> wb_dat_o == 32'h0)
        else $error("Unmapped read not zero.");
    a_io_req_held:
        assert property (io_req_o.req && !io_rsp_i.ack && io_rsp_i.present
            && ce_i |=> io_req_o.req && $stable(io_req_o.dev)
            && $stable(io_req_o.write))
        else $error("Device request changed early.");
    a_io_ack_ends:
        assert property (io_rsp_i.ack && ce_i |=> !io_req_o.req)
        else $error("Device request kept.");
    a_absent_out_ends:
        assert property (io_req_o.req && io_req_o.write && !io_rsp_i.present
            |-> ##[1:2] !io_req_o.req)
        else $error("Absent output did not end.");
    a_frozen_ce_low:
        assert property (!ce_i |=> $stable(io_req_o) && $stable(serv_o))
        else $error("State moved with enable low.");
endmodule

// *** testbench/io_dev_model.sv ***
module io_dev_model (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire console_pkg::io_req_t req_i,
    output console_pkg::io_rsp_t      rsp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  byte_q [$];
    logic [3:0]  boot_dev = 4'h0;
    int          slow = 0;
    int          starts = 0;
    int          cnt = 0;
    logic        ack = 1'b0;
    logic        here;
    logic [15:0] data = 16'h0000;

    assign here = req_i.req && (req_i.dev inside {4'h2, 4'h3, 4'h4,
                                                  [4'hB : 4'hE]});
    assign rsp_o = '{ack: ack, present: here, rdata: data};

    // Outside an answer the data lines toggle, as nobody drives them.
    always @(posedge clk_i) begin
        ack <= 1'b0;
        data <= ~data;
        if (rst_i || !req_i.req || ack) begin
            cnt <= 0;
        end else if (cnt < slow) begin
            cnt <= cnt + 1;
        end else begin
            ack <= 1'b1;
            if (here && req_i.write && req_i.ctrl && req_i.dev == boot_dev)
                starts <= starts + 1;
            if (here && !req_i.write)
                data <= {8'h5A, (req_i.dev == boot_dev && byte_q.size() > 0)
                                ? byte_q.pop_front() : 8'h00};
        end
    end
endmodule

// *** testbench/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic                 ce_i = 1'b1;
    logic [7:0]           adr = 8'h00;
    logic [31:0]          dat_w = 32'h0;
    logic                 we = 1'b0;
    logic                 cyc = 1'b0;
    logic                 stb = 1'b0;
    logic                 key_normal = 1'b1;
    logic                 irq = 1'b0;
    logic                 direct_memory_control = 1'b0;
    logic [31:0]          dat_o;
    logic                 ack;
    logic                 serv;
    console_pkg::io_req_t io_req;
    console_pkg::io_rsp_t io_rsp;
    int                   mismatches = 0;
    int                   cmp_count = 0;
    int                   regs [4];
    logic [15:0]          prog [13];
    logic [31:0]          rd;
    logic [15:0]          p, s, v, sum;
    logic [3:0]           devs [7] = '{2, 3, 4, 11, 12, 13, 14};

    always #4 clk_i = ~clk_i;

    console_control dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(adr),
        .wb_dat_i(dat_w), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .key_normal_i(key_normal), .irq_req_i(irq), .dmc_req_i(direct_memory_control),
        .io_req_o(io_req), .io_rsp_i(io_rsp), .serv_o(serv)
    );
    io_dev_model dev_m (.clk_i(clk_i), .rst_i(rst_i), .req_i(io_req),
                        .rsp_o(io_rsp));

    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 64);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        check({31'h0, ack}, 32'h1);
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic get(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic cmd(input int b);
        put(console_pkg::WB_CMD, 32'h1 << b);
    endtask

    task automatic mode(input logic [2:0] m);
        put(console_pkg::WB_CTRL, {29'h0, m});
    endtask

    task automatic set_reg(input logic [2:0] sl, input logic [15:0] val);
        put(console_pkg::WB_SEL, {29'h0, sl});
        cmd(console_pkg::CMD_CLEAR);
        put(console_pkg::WB_KEY, {16'h0, val});
        cmd(console_pkg::CMD_ENTER);
    endtask

    task automatic show(input logic [2:0] sl, input logic [15:0] e);
        int n = 0;
        put(console_pkg::WB_SEL, {29'h0, sl});
        do begin
            get(console_pkg::WB_DISP);
            n++;
        end while (rd !== {16'h0, e} && n < 200);
    endtask

    initial begin
        void'($urandom(32'hB00E));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        get(console_pkg::WB_MEMSZ);
        check(rd, 32'h1);
        put(8'h40, 32'hFFFF);
        get(8'h40);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            regs[i] = $urandom_range(0, 16'hFFFF);
            set_reg(3'(i), 16'(regs[i]));
        end
        for (int i = 0; i < 4; i++) begin
            show(3'(i), 16'(regs[i]));
            check(rd, 32'(regs[i]));
        end
        key_normal <= 1'b0;
        repeat (4) @(posedge clk_i);
        set_reg(console_pkg::SEL_A, ~16'(regs[0]));
        key_normal <= 1'b1;
        repeat (4) @(posedge clk_i);
        show(console_pkg::SEL_A, 16'(regs[0]));
        check(rd, 32'(regs[0]));
        s = 16'($urandom_range(0, 16'hFF0));
        v = 16'($urandom);
        p = 16'($urandom);
        set_reg(console_pkg::SEL_MADDR, s);
        set_reg(console_pkg::SEL_MDATA, v);
        set_reg(console_pkg::SEL_MDATA, p);
        show(console_pkg::SEL_MADDR, s + 16'd2);
        check(rd, {16'h0, s + 16'd2});
        set_reg(console_pkg::SEL_MADDR, s);
        show(console_pkg::SEL_MDATA, v);
        check(rd, {16'h0, v});
        cmd(console_pkg::CMD_ENTER);
        show(console_pkg::SEL_MDATA, p);
        check(rd, {16'h0, p});
        show(console_pkg::SEL_MADDR, s + 16'd1);
        check(rd, {16'h0, s + 16'd1});
        set_reg(console_pkg::SEL_MADDR, s + 16'h1000);
        set_reg(console_pkg::SEL_MDATA, ~v);
        set_reg(console_pkg::SEL_MADDR, s + 16'h1000);
        show(console_pkg::SEL_MDATA, 16'h0);
        check(rd, 32'h0);
        set_reg(console_pkg::SEL_MADDR, s);
        show(console_pkg::SEL_MDATA, v);
        check(rd, {16'h0, v});
        p = 16'($urandom_range(0, 16'hF00));
        set_reg(console_pkg::SEL_MADDR, p);
        for (int k = 0; k < 13; k++) begin
            prog[k] = {(k % 2 == 1) ? console_pkg::OP_CALL_SHORT + 5'(k / 2)
                                    : 5'h00, 11'($urandom)};
            set_reg(console_pkg::SEL_MDATA, prog[k]);
        end
        mode(console_pkg::MODE_STEP);
        set_reg(console_pkg::SEL_P, p);
        show(console_pkg::SEL_INST2, prog[1]);
        check(rd, {16'h0, prog[1]});
        prog[0] = {5'h00, 11'($urandom)};
        set_reg(console_pkg::SEL_INST1, prog[0]);
        show(console_pkg::SEL_INST1, prog[0]);
        check(rd, {16'h0, prog[0]});
        for (int k = 0; k < 7; k++) begin
            cmd(console_pkg::CMD_RUN);
            show(console_pkg::SEL_P, p + 16'(2 * k + 1));
            check(rd, {16'h0, p + 16'(2 * k + 1)});
        end
        mode(console_pkg::MODE_HALT);
        set_reg(console_pkg::SEL_P, p);
        direct_memory_control <= 1'b1;
        mode(console_pkg::MODE_RUN);
        put(console_pkg::WB_SEL, 32'(console_pkg::SEL_A));
        repeat (30) @(posedge clk_i);
        get(console_pkg::WB_DISP);
        check(rd, {16'h0, p});
        direct_memory_control <= 1'b0;
        irq <= 1'b1;
        repeat (30) @(posedge clk_i);
        mode(console_pkg::MODE_HALT);
        irq <= 1'b0;
        show(console_pkg::SEL_P, p);
        check(rd, {16'h0, p});
        mode(console_pkg::MODE_RUN);
        ce_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        ce_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        mode(console_pkg::MODE_HALT);
        put(console_pkg::WB_SEL, 32'(console_pkg::SEL_P));
        get(console_pkg::WB_DISP);
        check({31'h0, rd[15:0] !== p}, 32'h1);
        foreach (devs[d]) begin
            dev_m.boot_dev = devs[d];
            dev_m.slow = $urandom_range(0, 3);
            dev_m.starts = 0;
            dev_m.byte_q = '{8'h00, 8'h00};
            s = 16'($urandom_range(16'h100, 16'hF00));
            v = 16'($urandom);
            sum = 16'h0;
            for (int j = 0; j < 4; j++) begin
                prog[j] = (j < 3) ? {8'($urandom_range(1, 255)), 8'($urandom)}
                                  : 16'h0;
                sum += prog[j];
                dev_m.byte_q.push_back(prog[j][15:8]);
                dev_m.byte_q.push_back(prog[j][7:0]);
            end
            set_reg(console_pkg::SEL_P, s);
            set_reg(console_pkg::SEL_X, {12'h0, devs[d]});
            put(console_pkg::WB_KEY, {16'h0, v});
            mode(3'h5);
            cmd(console_pkg::CMD_INIT);
            show(console_pkg::SEL_P, v);
            check(rd, {16'h0, v});
            get(console_pkg::WB_SUM);
            check(rd, {16'h0, sum});
            check(32'(dev_m.starts), {31'h0, devs[d] != 4'h2});
            mode(console_pkg::MODE_HALT);
            for (int j = 0; j < 4; j++) begin
                set_reg(console_pkg::SEL_MADDR, s + 16'(j));
                show(console_pkg::SEL_MDATA, prog[j]);
                check(rd, {16'h0, prog[j]});
            end
        end
        dev_m.boot_dev = 4'h7;
        set_reg(console_pkg::SEL_X, 16'h0007);
        mode(3'h5);
        cmd(console_pkg::CMD_INIT);
        repeat (60) @(posedge clk_i);
        get(console_pkg::WB_SUM);
        check(rd, {16'h0, sum});
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        finish_test;
    end

    initial begin
        #400000;
        mismatches++;
        finish_test;
    end
endmodule

bind console_control console_checker chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(wb_adr_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_req_o(io_req_o),
    .io_rsp_i(io_rsp_i), .serv_o(serv_o)
);
